// [hw/ordering_cfg.svh]
// Sizes and reset values for the same-direction ordering engine.
// Included by the design files; holds definitions only.
`ifndef ORDERING_CFG_SVH
`define ORDERING_CFG_SVH

// =============================================================
// Structure
`define ORD_DQ_DEPTH    4
`define ORD_DATA_W      32
`define ORD_TAG_W       4
`define ORD_CNT_W       8
`define ORD_BUF_ENTRIES 2

// =============================================================
// Reset values
`define ORD_MODE_RST    1'b0
`define ORD_CNT_RST     8'h00

`endif

// [hw/ordering_pkg.sv]
// Types shared by the ordering engine, its target model and its bench.
// Assumes nothing of its surroundings.
package ordering_pkg;

	// =============================================================
	// Transaction classes, initiator answers, target engine states
	typedef enum logic [1:0] {KIND_MEM_WR, KIND_DLY_WR, KIND_DLY_RD} kind_type;
	typedef enum logic [1:0] {RSP_ACCEPT, RSP_RETRY, RSP_COMPLETE} rsp_type;
	typedef enum logic [1:0] {ST_IDLE, ST_PW, ST_DLY} state_type;

endpackage

// [hw/pw_buffer.sv]
// Two-entry posted write buffer with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "ordering_cfg.svh"

module pw_buffer #(
	parameter int DATA_W = `ORD_DATA_W
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [DATA_W-1:0] in_data,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [DATA_W-1:0]      out_data
);
	localparam int ENTRIES = `ORD_BUF_ENTRIES;

	logic [DATA_W-1:0] mem_q [ENTRIES];
	logic [DATA_W-1:0] mem_d [ENTRIES];
	logic              wr_ptr_q, wr_ptr_d;
	logic              rd_ptr_q, rd_ptr_d;
	logic [1:0]        cnt_q, cnt_d;
	logic              push, pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// =============================================================
	// Storage; words leave exactly as they entered, never merged
	always_comb begin
		mem_d    = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		cnt_d    = cnt_q;
		if (push) begin
			mem_d[wr_ptr_q] = in_data;
			wr_ptr_d        = !wr_ptr_q;
		end
		if (pop) begin
			rd_ptr_d = !rd_ptr_q;
		end
		case ({push, pop})
			2'b10: cnt_d = cnt_q + 2'h1;
			2'b01: cnt_d = cnt_q - 2'h1;
			default: cnt_d = cnt_q;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		mem_q <= mem_d;
		if (rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q    <= cnt_d;
		end
	end

	buf_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cnt_q == 2'h2 && !pop) |=> !in_ready)
		else $error("posted buffer accepted a word while full");
endmodule // pw_buffer

// [hw/fair_arbiter.sv]
// Fairness arbiter between the posted write queue and the delayed queue.
// Assumes take is raised only in a cycle where a grant is used.
`timescale 1ns/1ps

module fair_arbiter (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pw_req,
	input  wire logic dl_req,
	input  wire logic take,
	output logic      gnt_pw,
	output logic      gnt_dl
);
	logic last_pw_q, last_pw_d;

	// =============================================================
	// Alternate when both wait, so neither side starves
	always_comb begin
		gnt_pw    = pw_req && (!dl_req || !last_pw_q);
		gnt_dl    = dl_req && (!pw_req || last_pw_q);
		last_pw_d = last_pw_q;
		if (take) begin
			last_pw_d = gnt_pw;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_pw_q <= 1'b0;
		end else begin
			last_pw_q <= last_pw_d;
		end
	end

	alternate_a: assert property (@(posedge sys_clk) disable iff (rst)
		take && pw_req && dl_req |-> gnt_dl == last_pw_q)
		else $error("arbiter served posted writes twice while delayed waited");
endmodule // fair_arbiter

// [hw/ordering_engine.sv]
// Same-direction ordering engine of a two-bus bridge: posted write buffer,
// delayed transaction queue, completion hold and target-side scheduler.
// Assumes one instance per direction; the counter ports link the pair.
//
// Behaviour
// - Memory writes are posted: accepted once held in the buffer.
// - I/O and config writes are retried, queued, completed only after target finish.
// - All reads are retried on the initiator bus and queued as delayed reads.
// - A finished delayed request holds its response and read data as a completion.
// - Writes are never combined, byte-merged or collapsed.
// - Only a non-retry termination fixes a transaction's order.
// - No ordering between writes of the two directions; both accept and issue posted writes.
// - Posted write acceptance never waits on a mastered non-posted transaction.
// - Posted writes are accepted whatever state the delayed queue is in.
// - Posted writes reach the target in acceptance order.
// - A delayed read waits for every earlier posted write in its direction.
// - Read completion data waits for earlier posted writes travelling its way.
// - A delayed write never goes ahead of an earlier posted write.
// - Posted writes may pass delayed traffic; a fairness arbiter gives them turns.
// - Delayed requests and completions pass freely; write completions pass posted writes.
// - Ordered mode runs delayed requests in request order; clear allows reordering.
// - Out of order, a target retry lets another queued entry run next.
// - Out of order, with read buffers full, delayed writes go before reads.
// - Completions may return to initiators in any order.
`timescale 1ns/1ps
`include "ordering_cfg.svh"

module ordering_engine import ordering_pkg::*; #(
	parameter int DEPTH  = `ORD_DQ_DEPTH,
	parameter int DATA_W = `ORD_DATA_W,
	parameter int TAG_W  = `ORD_TAG_W,
	parameter int CNT_W  = `ORD_CNT_W
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ordered_mode,
	input  wire logic              rdbuf_full,
	input  wire logic              req_valid,
	input  wire kind_type          req_kind,
	input  wire logic [TAG_W-1:0]  req_tag,
	input  wire logic [DATA_W-1:0] req_data,
	output logic                   rsp_valid_q,
	output rsp_type                rsp_kind_q,
	output logic [TAG_W-1:0]       rsp_tag_q,
	output logic [DATA_W-1:0]      rsp_data_q,
	output logic                   tgt_valid_q,
	output kind_type               tgt_kind_q,
	output logic [TAG_W-1:0]       tgt_tag_q,
	output logic [DATA_W-1:0]      tgt_data_q,
	input  wire logic              tgt_done,
	input  wire logic              tgt_retry,
	input  wire logic [DATA_W-1:0] tgt_rdata,
	input  wire logic [CNT_W-1:0]  rev_accept_cnt,
	input  wire logic [CNT_W-1:0]  rev_retire_cnt,
	output logic [CNT_W-1:0]       pw_accept_cnt_q,
	output logic [CNT_W-1:0]       pw_retire_cnt_q
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || DEPTH > 16) begin : g_depth_check
		$error("DEPTH must lie between 2 and 16");
	end
	if (CNT_W < 4 || TAG_W < 1 || DATA_W < 1) begin : g_width_check
		$error("CNT_W, TAG_W or DATA_W too small");
	end

	// =============================================================
	// Delayed transaction queue
	logic              q_valid_q [DEPTH], q_valid_d [DEPTH];
	logic              q_done_q  [DEPTH], q_done_d  [DEPTH];
	logic              q_read_q  [DEPTH], q_read_d  [DEPTH];
	logic [TAG_W-1:0]  q_tag_q   [DEPTH], q_tag_d   [DEPTH];
	logic [DATA_W-1:0] q_data_q  [DEPTH], q_data_d  [DEPTH];
	logic [DATA_W-1:0] q_rdata_q [DEPTH], q_rdata_d [DEPTH];
	logic [CNT_W-1:0]  q_mark_q  [DEPTH], q_mark_d  [DEPTH];
	logic [CNT_W-1:0]  q_cmark_q [DEPTH], q_cmark_d [DEPTH];
	logic [CNT_W-1:0]  q_seq_q   [DEPTH], q_seq_d   [DEPTH];
	logic [CNT_W-1:0]  next_seq_q, next_seq_d;

	// Engine and answer state
	state_type         state_q, state_d;
	logic [IW-1:0]     cur_idx_q, cur_idx_d;
	logic [IW-1:0]     last_retry_q, last_retry_d;
	logic              last_retry_vld_q, last_retry_vld_d;
	logic              rsp_valid_d, tgt_valid_d;
	rsp_type           rsp_kind_d;
	kind_type          tgt_kind_d;
	logic [TAG_W-1:0]  rsp_tag_d, tgt_tag_d;
	logic [DATA_W-1:0] rsp_data_d, tgt_data_d;
	logic [CNT_W-1:0]  pw_accept_cnt_d, pw_retire_cnt_d;

	// Lookup and selection
	logic              hit, free_found, pick_found, pick1_found;
	logic [IW-1:0]     hit_idx, free_idx, pick_idx;
	logic              pending [DEPTH];
	logic              oldest  [DEPTH];
	logic              elig    [DEPTH];
	logic              rel     [DEPTH];
	logic              pw_push, pw_pop, pw_in_ready, pw_out_valid;
	logic [DATA_W-1:0] pw_out_data;
	logic              gnt_pw, gnt_dl, arb_take;

	// True once counter a has caught up with mark b, wrap-safe
	function automatic logic reached(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
		logic [CNT_W-1:0] diff;
		diff = a - b;
		return !diff[CNT_W-1];
	endfunction

	// =============================================================
	// Posted write path: a plain FIFO keeps acceptance order
	pw_buffer #(.DATA_W(DATA_W)) u_pw_buffer (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.in_valid (pw_push),
		.in_ready (pw_in_ready),
		.in_data  (req_data),
		.out_valid(pw_out_valid),
		.out_ready(pw_pop),
		.out_data (pw_out_data)
	);

	fair_arbiter u_fair_arbiter (
		.sys_clk(sys_clk),
		.rst    (rst),
		.pw_req (pw_out_valid && state_q == ST_IDLE),
		.dl_req (pick_found && state_q == ST_IDLE),
		.take   (arb_take),
		.gnt_pw (gnt_pw),
		.gnt_dl (gnt_dl)
	);

	assign arb_take = (state_q == ST_IDLE) && (gnt_pw || gnt_dl);

	// =============================================================
	// Queue lookup and target-side candidate selection
	always_comb begin
		hit         = 1'b0;
		hit_idx     = '0;
		free_found  = 1'b0;
		free_idx    = '0;
		pick_found  = 1'b0;
		pick1_found = 1'b0;
		pick_idx    = '0;
		for (int i = 0; i < DEPTH; i++) begin
			pending[i] = q_valid_q[i] && !q_done_q[i];
			// Read completions wait for the reverse direction's earlier posted writes
			rel[i] = q_done_q[i] &&
				(!q_read_q[i] || reached(rev_retire_cnt, q_cmark_q[i]));
			if (q_valid_q[i] && q_tag_q[i] == req_tag && !hit) begin
				hit     = 1'b1;
				hit_idx = IW'(i);
			end
			if (!q_valid_q[i] && !free_found) begin
				free_found = 1'b1;
				free_idx   = IW'(i);
			end
		end
		for (int i = 0; i < DEPTH; i++) begin
			oldest[i] = pending[i];
			for (int j = 0; j < DEPTH; j++) begin
				if (j != i && pending[j] && reached(q_seq_q[i], q_seq_q[j])) begin
					oldest[i] = 1'b0;
				end
			end
			elig[i] = pending[i] && reached(pw_retire_cnt_q, q_mark_q[i])
				&& !(q_read_q[i] && rdbuf_full)
				&& (!ordered_mode || oldest[i]);
		end
		// First pass skips the entry the target just retried
		for (int i = 0; i < DEPTH; i++) begin
			if (elig[i] && !pick1_found &&
				!(last_retry_vld_q && last_retry_q == IW'(i))) begin
				pick1_found = 1'b1;
				pick_idx    = IW'(i);
			end
		end
		pick_found = pick1_found;
		for (int i = 0; i < DEPTH; i++) begin
			if (elig[i] && !pick_found) begin
				pick_found = 1'b1;
				pick_idx   = IW'(i);
			end
		end
	end

	// =============================================================
	// Initiator answers, queue updates and the target engine
	always_comb begin
		q_valid_d        = q_valid_q;
		q_done_d         = q_done_q;
		q_read_d         = q_read_q;
		q_tag_d          = q_tag_q;
		q_data_d         = q_data_q;
		q_rdata_d        = q_rdata_q;
		q_mark_d         = q_mark_q;
		q_cmark_d        = q_cmark_q;
		q_seq_d          = q_seq_q;
		next_seq_d       = next_seq_q;
		state_d          = state_q;
		cur_idx_d        = cur_idx_q;
		last_retry_d     = last_retry_q;
		last_retry_vld_d = last_retry_vld_q;
		rsp_valid_d      = 1'b0;
		rsp_kind_d       = rsp_kind_q;
		rsp_tag_d        = rsp_tag_q;
		rsp_data_d       = rsp_data_q;
		tgt_valid_d      = tgt_valid_q;
		tgt_kind_d       = tgt_kind_q;
		tgt_tag_d        = tgt_tag_q;
		tgt_data_d       = tgt_data_q;
		pw_accept_cnt_d  = pw_accept_cnt_q;
		pw_retire_cnt_d  = pw_retire_cnt_q;
		pw_push          = 1'b0;
		pw_pop           = 1'b0;

		if (req_valid) begin
			rsp_valid_d = 1'b1;
			rsp_tag_d   = req_tag;
			rsp_data_d  = '0;
			rsp_kind_d  = RSP_RETRY;
			if (req_kind == KIND_MEM_WR) begin
				// Only buffer space gates a posted write, never delayed state
				if (pw_in_ready) begin
					pw_push         = 1'b1;
					rsp_kind_d      = RSP_ACCEPT;
					pw_accept_cnt_d = pw_accept_cnt_q + CNT_W'(1);
				end
			end else if (hit) begin
				if (rel[hit_idx]) begin
					rsp_kind_d         = RSP_COMPLETE;
					rsp_data_d         = q_rdata_q[hit_idx];
					q_valid_d[hit_idx] = 1'b0;
				end
			end else if (free_found) begin
				// Queued now, answered with retry until it has finished and its completion is released
				q_valid_d[free_idx] = 1'b1;
				q_done_d[free_idx]  = 1'b0;
				q_read_d[free_idx]  = (req_kind == KIND_DLY_RD);
				q_tag_d[free_idx]   = req_tag;
				q_data_d[free_idx]  = req_data;
				q_mark_d[free_idx]  = pw_accept_cnt_q;
				q_seq_d[free_idx]   = next_seq_q;
				next_seq_d          = next_seq_q + CNT_W'(1);
			end
		end

		case (state_q)
			ST_IDLE: begin
				if (gnt_pw) begin
					tgt_valid_d = 1'b1;
					tgt_kind_d  = KIND_MEM_WR;
					tgt_tag_d   = '0;
					tgt_data_d  = pw_out_data;
					state_d     = ST_PW;
				end else if (gnt_dl) begin
					tgt_valid_d = 1'b1;
					tgt_kind_d  = q_read_q[pick_idx] ? KIND_DLY_RD : KIND_DLY_WR;
					tgt_tag_d   = q_tag_q[pick_idx];
					tgt_data_d  = q_data_q[pick_idx];
					cur_idx_d   = pick_idx;
					state_d     = ST_DLY;
				end
			end
			ST_PW: begin
				if (tgt_done) begin
					tgt_valid_d = 1'b0;
					state_d     = ST_IDLE;
					if (!tgt_retry) begin
						pw_pop          = 1'b1;
						pw_retire_cnt_d = pw_retire_cnt_q + CNT_W'(1);
					end
				end
			end
			ST_DLY: begin
				if (tgt_done) begin
					tgt_valid_d = 1'b0;
					state_d     = ST_IDLE;
					if (tgt_retry) begin
						// Retried attempt leaves the entry pending, order unset
						last_retry_d     = cur_idx_q;
						last_retry_vld_d = 1'b1;
					end else begin
						q_done_d[cur_idx_q]  = 1'b1;
						q_rdata_d[cur_idx_q] = tgt_rdata;
						q_cmark_d[cur_idx_q] = rev_accept_cnt;
						last_retry_vld_d     = 1'b0;
					end
				end
			end
			default: begin
				state_d     = ST_IDLE;
				tgt_valid_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		q_tag_q   <= q_tag_d;
		q_data_q  <= q_data_d;
		q_rdata_q <= q_rdata_d;
		q_mark_q  <= q_mark_d;
		q_cmark_q <= q_cmark_d;
		q_seq_q   <= q_seq_d;
		q_read_q  <= q_read_d;
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				q_valid_q[i] <= 1'b0;
				q_done_q[i]  <= 1'b0;
			end
			next_seq_q       <= `ORD_CNT_RST;
			state_q          <= ST_IDLE;
			cur_idx_q        <= '0;
			last_retry_q     <= '0;
			last_retry_vld_q <= 1'b0;
			rsp_valid_q      <= 1'b0;
			rsp_kind_q       <= RSP_RETRY;
			rsp_tag_q        <= '0;
			rsp_data_q       <= '0;
			tgt_valid_q      <= 1'b0;
			tgt_kind_q       <= KIND_MEM_WR;
			tgt_tag_q        <= '0;
			tgt_data_q       <= '0;
			pw_accept_cnt_q  <= `ORD_CNT_RST;
			pw_retire_cnt_q  <= `ORD_CNT_RST;
		end else begin
			q_valid_q        <= q_valid_d;
			q_done_q         <= q_done_d;
			next_seq_q       <= next_seq_d;
			state_q          <= state_d;
			cur_idx_q        <= cur_idx_d;
			last_retry_q     <= last_retry_d;
			last_retry_vld_q <= last_retry_vld_d;
			rsp_valid_q      <= rsp_valid_d;
			rsp_kind_q       <= rsp_kind_d;
			rsp_tag_q        <= rsp_tag_d;
			rsp_data_q       <= rsp_data_d;
			tgt_valid_q      <= tgt_valid_d;
			tgt_kind_q       <= tgt_kind_d;
			tgt_tag_q        <= tgt_tag_d;
			tgt_data_q       <= tgt_data_d;
			pw_accept_cnt_q  <= pw_accept_cnt_d;
			pw_retire_cnt_q  <= pw_retire_cnt_d;
		end
	end

	// =============================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	pw_accept_a: assert property (req_valid && req_kind == KIND_MEM_WR && pw_in_ready
		|=> rsp_valid_q && rsp_kind_q == RSP_ACCEPT)
		else $error("posted write refused with buffer space free");
	dly_retry_a: assert property (req_valid && req_kind != KIND_MEM_WR && !hit
		|=> rsp_valid_q && rsp_kind_q == RSP_RETRY)
		else $error("new delayed request not retried");
	dly_after_pw_a: assert property (state_q == ST_IDLE && gnt_dl
		|=> tgt_valid_q && reached(pw_retire_cnt_q, q_mark_q[cur_idx_q]))
		else $error("delayed request issued ahead of earlier posted write");
	rd_cpl_wait_a: assert property (req_valid && req_kind == KIND_DLY_RD && hit
		&& !rel[hit_idx] |=> rsp_kind_q == RSP_RETRY)
		else $error("read completion released before posted writes");
	retry_keeps_a: assert property (state_q == ST_DLY && tgt_done && tgt_retry
		|=> q_valid_q[$past(cur_idx_q)] && !q_done_q[$past(cur_idx_q)])
		else $error("target retry changed the entry's order state");
	ordered_pick_a: assert property (state_q == ST_IDLE && gnt_dl && ordered_mode
		|-> oldest[pick_idx])
		else $error("ordered mode issued a younger delayed request");
	rdfull_skip_a: assert property (state_q == ST_IDLE && gnt_dl && rdbuf_full
		|-> !q_read_q[pick_idx])
		else $error("delayed read issued with read buffers full");
	retry_move_a: assert property (pick1_found && last_retry_vld_q
		|-> pick_idx != last_retry_q)
		else $error("retried entry chosen while another was eligible");
	pw_retire_a: assert property (state_q == ST_PW && tgt_done && !tgt_retry
		|=> pw_retire_cnt_q == CNT_W'($past(pw_retire_cnt_q) + CNT_W'(1)))
		else $error("posted write completion not counted");

	pw_during_dly_c: cover property (state_q == ST_DLY && req_valid && req_kind == KIND_MEM_WR
		&& pw_in_ready);
	dly_complete_c: cover property (rsp_valid_q && rsp_kind_q == RSP_COMPLETE);
	tgt_retry_c: cover property (state_q == ST_DLY && tgt_done && tgt_retry);
	wr_past_rd_c: cover property (state_q == ST_IDLE && gnt_dl && rdbuf_full);
endmodule // ordering_engine

// [verification/target_model.sv]
// Target-side stand-in for one direction of the ordering engine.
// Assumes the engine's tgt_* handshake and one shared clock.
`timescale 1ns/1ps

module target_model import ordering_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        tgt_valid_q,
	input  wire kind_type    tgt_kind_q,
	input  wire logic [3:0]  tgt_tag_q,
	input  wire logic [31:0] tgt_data_q,
	input  wire logic        hold,
	input  wire logic        retry_on,
	input  wire logic [3:0]  lat,
	output logic             tgt_done,
	output logic             tgt_retry,
	output logic [31:0]      tgt_rdata
);
	// =============================================================
	// Attempt log, read by the bench
	kind_type    lk [64];
	logic [3:0]  lt [64];
	logic [31:0] ld [64];
	int          n_log;
	logic [3:0]  wait_q;

	// =============================================================
	// Answer logic
	// Released lines toggle so a stale value never looks valid
	always_ff @(posedge sys_clk) begin
		tgt_retry <= ~tgt_retry;
		tgt_rdata <= ~tgt_rdata;
		tgt_done  <= 1'h0;
		if (rst) begin
			tgt_retry <= 1'h0;
			tgt_rdata <= 32'h0;
			wait_q    <= 4'h0;
			n_log     <= 0;
		end else if (tgt_valid_q && !tgt_done && !hold) begin
			if (wait_q >= lat) begin
				tgt_done        <= 1'h1;
				tgt_retry       <= retry_on;
				tgt_rdata       <= 32'hd000_0000 | tgt_tag_q;
				lk[n_log % 64]  <= tgt_kind_q;
				lt[n_log % 64]  <= tgt_tag_q;
				ld[n_log % 64]  <= tgt_data_q;
				n_log           <= n_log + 1;
				wait_q          <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule // target_model

// [verification/bridge_transaction_ordering_tb.sv]
// Self-checking bench for one direction of the ordering engine.
// Assumes target_model on the target side; the bench plays the initiator.
`timescale 1ns/1ps

module bridge_transaction_ordering_tb import ordering_pkg::*;;
	logic        sys_clk, rst, ordered_mode, rdbuf_full, req_valid;
	logic        rsp_valid_q, tgt_valid_q, tgt_done, tgt_retry, hold, retry_on;
	kind_type    req_kind, tgt_kind_q;
	rsp_type     rsp_kind_q;
	logic [3:0]  req_tag, rsp_tag_q, tgt_tag_q, lat;
	logic [31:0] req_data, rsp_data_q, tgt_data_q, tgt_rdata;
	logic [7:0]  rev_acc, rev_ret, acc_cnt, ret_cnt;
	int          errors, num_checks, base;

	ordering_engine u_dut (.sys_clk(sys_clk), .rst(rst), .ordered_mode(ordered_mode),
		.rdbuf_full(rdbuf_full), .req_valid(req_valid), .req_kind(req_kind),
		.req_tag(req_tag), .req_data(req_data), .rsp_valid_q(rsp_valid_q),
		.rsp_kind_q(rsp_kind_q), .rsp_tag_q(rsp_tag_q), .rsp_data_q(rsp_data_q),
		.tgt_valid_q(tgt_valid_q), .tgt_kind_q(tgt_kind_q), .tgt_tag_q(tgt_tag_q),
		.tgt_data_q(tgt_data_q), .tgt_done(tgt_done), .tgt_retry(tgt_retry),
		.tgt_rdata(tgt_rdata), .rev_accept_cnt(rev_acc), .rev_retire_cnt(rev_ret),
		.pw_accept_cnt_q(acc_cnt), .pw_retire_cnt_q(ret_cnt));

	target_model u_tgt (.sys_clk(sys_clk), .rst(rst), .tgt_valid_q(tgt_valid_q),
		.tgt_kind_q(tgt_kind_q), .tgt_tag_q(tgt_tag_q), .tgt_data_q(tgt_data_q),
		.hold(hold), .retry_on(retry_on), .lat(lat), .tgt_done(tgt_done),
		.tgt_retry(tgt_retry), .tgt_rdata(tgt_rdata));

	always #12.5 sys_clk = ~sys_clk;

	// =============================================================
	// Shared tasks
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// One initiator attempt; answer looked at in its single valid cycle
	task automatic req(input kind_type k, input logic [3:0] t, input logic [31:0] d,
			input rsp_type e, input bit last);
		req_valid = 1'h1;
		req_kind  = k;
		req_tag   = t;
		req_data  = d;
		@(negedge sys_clk);
		if (last) req_valid = 1'h0;
		chk("rsp", {1'h1, e, t}, {rsp_valid_q, rsp_kind_q, rsp_tag_q});
	endtask

	task automatic logw(input int n);
		for (int i = 0; i < 300 && u_tgt.n_log < n; i++) @(negedge sys_clk);
		if (u_tgt.n_log < n) begin
			errors++;
			$display("wrong value target attempts expected %0d seen %0d", n, u_tgt.n_log);
			end_of_test();
		end
	endtask

	task automatic lg(input int i, input kind_type k, input logic [3:0] t, input logic [31:0] d);
		chk("target log", {k, t, d}, {u_tgt.lk[i % 64], u_tgt.lt[i % 64], u_tgt.ld[i % 64]});
	endtask

	// =============================================================
	// Scenarios
	task automatic t_post();
		base = u_tgt.n_log;
		lat  = 4'h0;
		hold = 1'h1;
		req(KIND_MEM_WR, 4'h0, 32'haa, RSP_ACCEPT, 0);
		req(KIND_MEM_WR, 4'h0, 32'haa, RSP_ACCEPT, 1);
		tick(3);
		req(KIND_MEM_WR, 4'h0, 32'hbb, RSP_RETRY, 0);
		req(KIND_MEM_WR, 4'h0, 32'hcc, RSP_RETRY, 1);
		hold = 1'h0;
		logw(base + 2);
		lg(base, KIND_MEM_WR, 4'h0, 32'haa);
		lg(base + 1, KIND_MEM_WR, 4'h0, 32'haa);
		tick(2);
		chk("target attempts", 40'(base + 2), 40'(u_tgt.n_log));
		chk("pw counts", {8'h2, 8'h2}, {acc_cnt, ret_cnt});
	endtask

	task automatic t_read();
		base = u_tgt.n_log;
		lat  = 4'h2;
		hold = 1'h1;
		req(KIND_MEM_WR, 4'h0, 32'h33, RSP_ACCEPT, 1);
		req(KIND_DLY_RD, 4'h3, 32'h300, RSP_RETRY, 1);
		rev_acc = 8'h1;
		tick(3);
		hold = 1'h0;
		logw(base + 2);
		lg(base, KIND_MEM_WR, 4'h0, 32'h33);
		lg(base + 1, KIND_DLY_RD, 4'h3, 32'h300);
		tick(2);
		req(KIND_DLY_RD, 4'h3, 32'h300, RSP_RETRY, 1);
		rev_ret = 8'h1;
		tick(1);
		req(KIND_DLY_RD, 4'h3, 32'h300, RSP_COMPLETE, 1);
		chk("rdata", 32'hd000_0003, rsp_data_q);
	endtask

	task automatic t_dwr();
		base = u_tgt.n_log;
		hold = 1'h1;
		req(KIND_MEM_WR, 4'h0, 32'h44, RSP_ACCEPT, 1);
		req(KIND_DLY_WR, 4'h5, 32'h55, RSP_RETRY, 1);
		req(KIND_DLY_WR, 4'h5, 32'h55, RSP_RETRY, 1);
		hold = 1'h0;
		logw(base + 2);
		lg(base, KIND_MEM_WR, 4'h0, 32'h44);
		lg(base + 1, KIND_DLY_WR, 4'h5, 32'h55);
		tick(2);
		req(KIND_DLY_WR, 4'h5, 32'h55, RSP_COMPLETE, 1);
	endtask

	task automatic t_pass();
		base = u_tgt.n_log;
		hold = 1'h1;
		req(KIND_DLY_RD, 4'h6, 32'h600, RSP_RETRY, 1);
		tick(4);
		req(KIND_MEM_WR, 4'h0, 32'h66, RSP_ACCEPT, 1);
		hold = 1'h0;
		logw(base + 2);
		lg(base + 1, KIND_MEM_WR, 4'h0, 32'h66);
		tick(2);
		req(KIND_DLY_RD, 4'h6, 32'h600, RSP_COMPLETE, 1);
		chk("rdata", 32'hd000_0006, rsp_data_q);
	endtask

	task automatic t_ooo(input bit m);
		base = u_tgt.n_log;
		ordered_mode = m;
		hold = 1'h1;
		retry_on = 1'h1;
		req(KIND_DLY_RD, 4'h1, 32'h100, RSP_RETRY, 1);
		req(KIND_DLY_RD, 4'h2, 32'h200, RSP_RETRY, 1);
		hold = 1'h0;
		logw(base + 1);
		retry_on = 1'h0;
		lg(base, KIND_DLY_RD, 4'h1, 32'h100);
		logw(base + 2);
		if (m) lg(base + 1, KIND_DLY_RD, 4'h1, 32'h100);
		else lg(base + 1, KIND_DLY_RD, 4'h2, 32'h200);
		logw(base + 3);
		tick(2);
		// Both outstanding requests are repeated, neither waits on the other
		req(KIND_DLY_RD, 4'h2, 32'h200, RSP_COMPLETE, 1);
		chk("rdata", 32'hd000_0002, rsp_data_q);
		req(KIND_DLY_RD, 4'h1, 32'h100, RSP_COMPLETE, 1);
		chk("rdata", 32'hd000_0001, rsp_data_q);
		ordered_mode = 1'h0;
	endtask

	task automatic t_full();
		base = u_tgt.n_log;
		rdbuf_full = 1'h1;
		req(KIND_DLY_RD, 4'h7, 32'h700, RSP_RETRY, 1);
		req(KIND_DLY_WR, 4'h8, 32'h800, RSP_RETRY, 1);
		logw(base + 1);
		lg(base, KIND_DLY_WR, 4'h8, 32'h800);
		rdbuf_full = 1'h0;
		logw(base + 2);
		tick(2);
		req(KIND_DLY_WR, 4'h8, 32'h800, RSP_COMPLETE, 1);
		req(KIND_DLY_RD, 4'h7, 32'h700, RSP_COMPLETE, 1);
		chk("rdata", 32'hd000_0007, rsp_data_q);
	endtask

	// =============================================================
	// Main sequence
	initial begin
		sys_clk = 1'h0;
		rst = 1'h1;
		ordered_mode = 1'h0;
		rdbuf_full = 1'h0;
		req_valid = 1'h0;
		req_kind = KIND_MEM_WR;
		req_tag = 4'h0;
		req_data = 32'h0;
		hold = 1'h0;
		retry_on = 1'h0;
		lat = 4'h2;
		rev_acc = 8'h0;
		rev_ret = 8'h0;
		errors = 0;
		num_checks = 0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'h0;
		@(negedge sys_clk);
		t_post();
		t_read();
		t_dwr();
		t_pass();
		t_ooo(1'h0);
		t_ooo(1'h1);
		t_full();
		end_of_test();
	end
endmodule // bridge_transaction_ordering_tb
